// ### common/ivc_pkg.sv
package ivc_pkg;

    // ************************************************************
    // source layout
    // ************************************************************
    localparam int NUM_SRC = 64;
    localparam int FLAG_REGS = 4;
    localparam int PRIO_REGS = 16;
    localparam logic [6:0] VECTOR_BASE = 7'h08;
    localparam logic [23:0] TABLE_BASE = 24'h000004;
    // bit n set where request number n has flag, enable and priority
    localparam logic [63:0] SRC_IMPL_MASK = 64'h0206_007F_FF1F_7FFF;
    localparam int CAN_RX_IRQ = 34;
    localparam int CAN_EVT_IRQ = 35;
    localparam int PWM_MATCH_IRQ = 57;
    localparam int EXT_ZERO_IRQ = 0;
    localparam int EXT_ONE_IRQ = 20;
    localparam int EXT_TWO_IRQ = 29;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_BLOCK_ALL = 3'h7;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] FLAG_REG_FIRST_ADDR = 8'h00;
    localparam logic [7:0] ENABLE_REG_FIRST_ADDR = 8'h10;
    localparam logic [7:0] PRIORITY_REG_FIRST_ADDR = 8'h20;
    localparam logic [7:0] GLOBAL_CONTROL_ADDR = 8'h60;
    localparam logic [7:0] PENDING_ADDR = 8'h64;
    localparam logic [7:0] EVT_STATUS_ADDR = 8'h68;
    localparam logic [7:0] EVT_CLEAR_ADDR = 8'h6C;
    localparam logic [7:0] EVT_ENABLE_ADDR = 8'h70;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int GIE_BIT = 15;
    localparam int DISABLE_INSTR_ACTIVE_BIT = 14;
    localparam int SOFTWARE_TRAP_BIT_BIT = 13;
    localparam int EDGE_SEL_LSB = 0;
    localparam logic [15:0] CTRL_RESET = 16'h8000;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'hA007;

    // ************************************************************
    // event bits
    // ************************************************************
    localparam int EVT_WIDTH = 2;
    localparam int EVT_ACK = 0;
    localparam int EVT_EXT_EDGE = 1;

endpackage

// ### core/ivc_edge_detect.sv
`timescale 1ns/1ps
module ivc_edge_detect
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pinIn,
    input wire logic negEdgeSel,
    output logic edgePulse
);

    logic prevQ;
    logic prevD;
    logic pulseQ;
    logic pulseD;

    always_comb
    begin
        prevD = pinIn;
        // set select bit means falling edge
        pulseD = negEdgeSel ? (prevQ & ~pinIn) : (~prevQ & pinIn);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prevQ <= 1'b0;
            pulseQ <= 1'b0;
        end
        else
        begin
            prevQ <= prevD;
            pulseQ <= pulseD;
        end
    end

    assign edgePulse = pulseQ;

endmodule

// ### core/ivc_interrupt_vector_control.sv
// Notes on behaviour
// - External pin zero is vector 8, request 0, table 0x000014, flag/enable bit 0, prio field 0.
// - DMA channel zero is vector 12, request 4, table 0x00001C, prio in bits 2:0 of prio reg 1.
// - SPI one transfer done is vector 18, request 10, table 0x000028, flag bit 10 of reg 0.
// - I2C one slave is vector 24, request 16, table 0x000034, flag bit 0 of flag reg 1.
// - Pin change is vector 27, request 19, table 0x00003A, flag/enable bit 3 of reg 1.
// - External pin one is vector 28, request 20, table 0x00003C, prio bits 2:0 of prio reg 5.
// - DMA channel two is vector 32, request 24, table 0x000044, flag bit 8 of flag reg 1.
// - UART two transmit is vector 39, request 31, table 0x000052, bit 15 of reg 1.
// - CAN receive ready, when present, is vector 42, request 34, table 0x000058.
// - I2C two master is vector 58, request 50, table 0x000078, prio bits 10:8 of reg 12.
// - PWM match, motor variants only, is vector 65, request 57, prio bits 6:4 of reg 14.
// - Global enable at control bit 15, reset one, gates irqReq when cleared; irqOut and softwareTrapReq are not gated.
// - A core priority level of 111 blocks every user interrupt.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module ivc_interrupt_vector_control
#(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_PWM = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [63:0] srcEvent,
    input wire logic extPinIrqZero,
    input wire logic extPinIrqOne,
    input wire logic extPinIrqTwo,
    input wire logic [2:0] corePriorityLevel,
    input wire logic disableInstrIn,
    input wire logic irqAck,
    output logic irqReq,
    output logic [6:0] irqVector,
    output logic [2:0] irqPriority,
    output logic [23:0] irqTableAddr,
    output logic softwareTrapReq,
    output logic irqOut
);

    // ************************************************************
    // source masks and pin edges
    // ************************************************************
    localparam logic [63:0] VARIANT_MASK = ~(
        ((HAS_CAN ? 64'h0 : 64'h1) << ivc_pkg::CAN_RX_IRQ) |
        ((HAS_CAN ? 64'h0 : 64'h1) << ivc_pkg::CAN_EVT_IRQ) |
        ((HAS_PWM ? 64'h0 : 64'h1) << ivc_pkg::PWM_MATCH_IRQ));
    localparam logic [63:0] IMPL = ivc_pkg::SRC_IMPL_MASK & VARIANT_MASK;

    logic [2:0] extEdge;
    logic [15:0] ctrlQ;
    logic [15:0] ctrlD;

    ivc_edge_detect uEdgeZero
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(extPinIrqZero),
        .negEdgeSel(ctrlQ[ivc_pkg::EDGE_SEL_LSB]),
        .edgePulse(extEdge[0])
    );

    ivc_edge_detect uEdgeOne
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(extPinIrqOne),
        .negEdgeSel(ctrlQ[ivc_pkg::EDGE_SEL_LSB + 1]),
        .edgePulse(extEdge[1])
    );

    ivc_edge_detect uEdgeTwo
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(extPinIrqTwo),
        .negEdgeSel(ctrlQ[ivc_pkg::EDGE_SEL_LSB + 2]),
        .edgePulse(extEdge[2])
    );

    logic [63:0] setVec;

    always_comb
    begin
        setVec = srcEvent;
        setVec[ivc_pkg::EXT_ZERO_IRQ] = srcEvent[ivc_pkg::EXT_ZERO_IRQ] | extEdge[0];
        setVec[ivc_pkg::EXT_ONE_IRQ] = srcEvent[ivc_pkg::EXT_ONE_IRQ] | extEdge[1];
        setVec[ivc_pkg::EXT_TWO_IRQ] = srcEvent[ivc_pkg::EXT_TWO_IRQ] | extEdge[2];
        setVec = setVec & IMPL;
    end

    // ************************************************************
    // avalon slave handshake
    // ************************************************************
    logic waitQ;
    logic waitD;
    logic wrFire;
    logic [15:0] byteMask;
    logic [15:0] wData;
    logic [5:0] wIdx;

    always_comb
    begin
        waitD = ~((avs_read | avs_write) & waitQ);
        wrFire = avs_write & ~waitQ & (avs_address[1:0] == 2'h0);
        byteMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wData = avs_writedata[15:0] & byteMask;
        wIdx = avs_address[7:2];
    end

    // ************************************************************
    // flag, enable, priority storage
    // ************************************************************
    logic [63:0] flagQ;
    logic [63:0] flagD;
    logic [63:0] enQ;
    logic [63:0] enD;
    logic [2:0] prioQ [ivc_pkg::NUM_SRC];
    logic [2:0] prioD [ivc_pkg::NUM_SRC];

    always_comb
    begin
        flagD = flagQ;
        enD = enQ;
        for (int i = 0; i < ivc_pkg::NUM_SRC; i++)
        begin
            prioD[i] = prioQ[i];
        end
        if (wrFire && avs_address < ivc_pkg::ENABLE_REG_FIRST_ADDR)
        begin
            // flag n sits in reg n/16, bit n%16
            for (int b = 0; b < 16; b++)
            begin
                if (byteMask[b])
                begin
                    flagD[{wIdx[1:0], 4'(b)}] = wData[b];
                end
            end
        end
        if (wrFire && avs_address >= ivc_pkg::ENABLE_REG_FIRST_ADDR &&
            avs_address < ivc_pkg::PRIORITY_REG_FIRST_ADDR)
        begin
            for (int b = 0; b < 16; b++)
            begin
                if (byteMask[b])
                begin
                    enD[{wIdx[1:0], 4'(b)}] = wData[b];
                end
            end
        end
        if (wrFire && avs_address >= ivc_pkg::PRIORITY_REG_FIRST_ADDR &&
            avs_address < ivc_pkg::GLOBAL_CONTROL_ADDR)
        begin
            // field j of prio reg k is source 4k+j, bits 4j+2:4j
            for (int j = 0; j < 4; j++)
            begin
                if (byteMask[4 * j])
                begin
                    prioD[{wIdx[3:0] - 4'h8, 2'(j)}] = wData[4 * j +: 3];
                end
            end
        end
        // hardware set wins over software clear
        flagD = (flagD | setVec) & IMPL;
        enD = enD & IMPL;
        for (int i = 0; i < ivc_pkg::NUM_SRC; i++)
        begin
            if (!IMPL[i])
            begin
                prioD[i] = 3'h0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flagQ <= 64'h0;
            enQ <= 64'h0;
            for (int i = 0; i < ivc_pkg::NUM_SRC; i++)
            begin
                prioQ[i] <= IMPL[i] ? ivc_pkg::PRIO_RESET : 3'h0;
            end
        end
        else
        begin
            flagQ <= flagD;
            enQ <= enD;
            for (int i = 0; i < ivc_pkg::NUM_SRC; i++)
            begin
                prioQ[i] <= prioD[i];
            end
        end
    end

    // ************************************************************
    // global control and events
    // ************************************************************
    logic [1:0] evtStatQ;
    logic [1:0] evtStatD;
    logic [1:0] evtEnQ;
    logic [1:0] evtEnD;
    logic irqOutQ;
    logic irqOutD;

    always_comb
    begin
        ctrlD = ctrlQ;
        evtEnD = evtEnQ;
        evtStatD = evtStatQ;
        if (wrFire && avs_address == ivc_pkg::GLOBAL_CONTROL_ADDR)
        begin
            ctrlD = (ctrlQ & ~(byteMask & ivc_pkg::CTRL_WRITE_MASK)) |
                    (wData & ivc_pkg::CTRL_WRITE_MASK);
        end
        ctrlD[ivc_pkg::DISABLE_INSTR_ACTIVE_BIT] = disableInstrIn;
        if (wrFire && avs_address == ivc_pkg::EVT_CLEAR_ADDR)
        begin
            evtStatD = evtStatQ & ~wData[1:0];
        end
        if (wrFire && avs_address == ivc_pkg::EVT_ENABLE_ADDR)
        begin
            evtEnD = wData[1:0];
        end
        evtStatD[ivc_pkg::EVT_ACK] = evtStatD[ivc_pkg::EVT_ACK] | irqAck;
        evtStatD[ivc_pkg::EVT_EXT_EDGE] = evtStatD[ivc_pkg::EVT_EXT_EDGE] | (|extEdge);
        irqOutD = |(evtStatD & evtEnD);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrlQ <= ivc_pkg::CTRL_RESET;
            evtStatQ <= 2'h0;
            evtEnQ <= 2'h0;
            irqOutQ <= 1'b0;
        end
        else
        begin
            ctrlQ <= ctrlD;
            evtStatQ <= evtStatD;
            evtEnQ <= evtEnD;
            irqOutQ <= irqOutD;
        end
    end

    // ************************************************************
    // arbitration
    // ************************************************************
    logic [63:0] eligible;
    logic [2:0] bestPrio;
    logic [5:0] bestIdx;
    logic reqD;
    logic reqQ;
    logic [6:0] vecD;
    logic [6:0] vecQ;
    logic [2:0] prioOutQ;
    logic [23:0] addrD;
    logic [23:0] addrQ;

    always_comb
    begin
        bestPrio = 3'h0;
        bestIdx = 6'h0;
        for (int i = 0; i < ivc_pkg::NUM_SRC; i++)
        begin
            eligible[i] = flagQ[i] & enQ[i] & IMPL[i] & (prioQ[i] > corePriorityLevel);
            // strict compare keeps the lowest vector on a tie
            if (eligible[i] && prioQ[i] > bestPrio)
            begin
                bestPrio = prioQ[i];
                bestIdx = 6'(i);
            end
        end
        reqD = ctrlQ[ivc_pkg::GIE_BIT] & (|eligible) &
               (corePriorityLevel != ivc_pkg::PRIO_BLOCK_ALL);
        vecD = ivc_pkg::VECTOR_BASE + {1'b0, bestIdx};
        addrD = ivc_pkg::TABLE_BASE + {16'h0, vecD, 1'b0};
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqQ <= 1'b0;
            vecQ <= 7'h0;
            prioOutQ <= 3'h0;
            addrQ <= 24'h0;
        end
        else
        begin
            reqQ <= reqD;
            vecQ <= reqD ? vecD : 7'h0;
            prioOutQ <= reqD ? bestPrio : 3'h0;
            addrQ <= reqD ? addrD : 24'h0;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    logic [31:0] rdQ;
    logic [31:0] rdD;

    always_comb
    begin
        rdD = rdQ;
        if (avs_read && waitQ)
        begin
            rdD = 32'h0;
            if (avs_address < ivc_pkg::ENABLE_REG_FIRST_ADDR && avs_address[1:0] == 2'h0)
            begin
                rdD[15:0] = flagQ[{wIdx[1:0], 4'h0} +: 16];
            end
            else if (avs_address < ivc_pkg::PRIORITY_REG_FIRST_ADDR && avs_address[1:0] == 2'h0)
            begin
                rdD[15:0] = enQ[{wIdx[1:0], 4'h0} +: 16];
            end
            else if (avs_address < ivc_pkg::GLOBAL_CONTROL_ADDR && avs_address[1:0] == 2'h0)
            begin
                for (int j = 0; j < 4; j++)
                begin
                    rdD[4 * j +: 3] = prioQ[{wIdx[3:0] - 4'h8, 2'(j)}];
                end
            end
            else if (avs_address == ivc_pkg::GLOBAL_CONTROL_ADDR)
            begin
                rdD[15:0] = ctrlQ;
            end
            else if (avs_address == ivc_pkg::PENDING_ADDR)
            begin
                rdD[15:0] = {reqQ, 5'h0, prioOutQ, vecQ};
            end
            else if (avs_address == ivc_pkg::EVT_STATUS_ADDR)
            begin
                rdD[1:0] = evtStatQ;
            end
            else if (avs_address == ivc_pkg::EVT_ENABLE_ADDR)
            begin
                rdD[1:0] = evtEnQ;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waitQ <= 1'b1;
            rdQ <= 32'h0;
        end
        else
        begin
            waitQ <= waitD;
            rdQ <= rdD;
        end
    end

    assign avs_readdata = rdQ;
    assign avs_waitrequest = waitQ;
    assign irqReq = reqQ;
    assign irqVector = vecQ;
    assign irqPriority = prioOutQ;
    assign irqTableAddr = addrQ;
    assign softwareTrapReq = ctrlQ[ivc_pkg::SOFTWARE_TRAP_BIT_BIT];
    assign irqOut = irqOutQ;

endmodule

// ### tb/ivc_checker.sv
`timescale 1ns/1ps
module ivc_checker
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] corePriorityLevel,
    input wire logic irqReq,
    input wire logic [6:0] irqVector,
    input wire logic [2:0] irqPriority,
    input wire logic [23:0] irqTableAddr,
    input wire logic irqOut
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_wait_cause;
        !avs_waitrequest |-> $past(avs_read || avs_write);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_hi_zero;
        avs_readdata[31:16] == 16'h0000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read data set");
    property p_vec_addr;
        irqReq |-> irqTableAddr == 24'h000004 + {16'h0000, irqVector, 1'b0};
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("table address wrong");
    property p_idle_zero;
        !irqReq |-> (irqVector == 7'h00) && (irqPriority == 3'h0) && (irqTableAddr == 24'h0);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle outputs not zero");
    property p_impl;
        irqReq |-> irqVector >= 7'h08 && ivc_pkg::SRC_IMPL_MASK[irqVector - 7'h08];
    endproperty
    a_impl: assert property (p_impl) else $error("reserved vector offered");
    property p_block7;
        irqReq |-> $past(corePriorityLevel) != 3'h7;
    endproperty
    a_block7: assert property (p_block7) else $error("request at level seven");
    property p_prio;
        irqReq |-> irqPriority > $past(corePriorityLevel);
    endproperty
    a_prio: assert property (p_prio) else $error("priority not above level");
    c_req: cover property ($rose(irqReq));
    c_out: cover property ($rose(irqOut));
    c_acc: cover property (avs_write && !avs_waitrequest);
endmodule
bind ivc_interrupt_vector_control ivc_checker u_chk
(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .corePriorityLevel(corePriorityLevel),
    .irqReq(irqReq),
    .irqVector(irqVector),
    .irqPriority(irqPriority),
    .irqTableAddr(irqTableAddr),
    .irqOut(irqOut)
);

// ### tb/ivc_core_model.sv
`timescale 1ns/1ps
module ivc_core_model
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic irqReq,
    input wire logic [3:0] ackDelay,
    output logic irqAck
);
    logic reqQ;
    logic [4:0] waitCnt;
    // acks each new request after a variable delay, only if still offered
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqQ <= 1'b0;
            waitCnt <= 5'h00;
            irqAck <= 1'b0;
        end
        else
        begin
            reqQ <= irqReq;
            irqAck <= irqReq && reqQ && (waitCnt == 5'h01);
            if (irqReq && !reqQ)
                waitCnt <= {1'b0, ackDelay} + 5'h01;
            else if (waitCnt != 5'h00)
                waitCnt <= waitCnt - 5'h01;
        end
    end
endmodule

// ### tb/tb_interrupt_vector_control.sv
`timescale 1ns/1ps
module tb_interrupt_vector_control;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic waitReq, irqAck, irqReq, irqOut, trap;
    logic [63:0] srcEvent = 64'h0;
    logic [2:0] extPin = 3'h0;
    logic [2:0] level = 3'h0;
    logic disable_instr_active = 1'b0;
    logic [3:0] ackDelay = 4'h0;
    logic [6:0] irqVector;
    logic [2:0] irqPriority, p;
    logic [23:0] irqTableAddr;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'h0425;
    int n;
    int srcList [11] = '{0, 4, 10, 16, 19, 20, 24, 31, 34, 50, 57};
    int vecList [11] = '{8, 12, 18, 24, 27, 28, 32, 39, 42, 58, 65};
    int tblList [11] = '{32'h14, 32'h1C, 32'h28, 32'h34, 32'h3A, 32'h3C, 32'h44, 32'h52,
        32'h58, 32'h78, 32'h86};
    logic [3:0] be = 4'hF;
    always #5 clk_sys = ~clk_sys;
    ivc_interrupt_vector_control u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitReq), .srcEvent(srcEvent),
        .extPinIrqZero(extPin[0]), .extPinIrqOne(extPin[1]), .extPinIrqTwo(extPin[2]),
        .corePriorityLevel(level), .disableInstrIn(disable_instr_active), .irqAck(irqAck), .irqReq(irqReq),
        .irqVector(irqVector), .irqPriority(irqPriority), .irqTableAddr(irqTableAddr),
        .softwareTrapReq(trap), .irqOut(irqOut));
    ivc_core_model u_core (.clk_sys(clk_sys), .rst_b(rst_b), .irqReq(irqReq),
        .ackDelay(ackDelay), .irqAck(irqAck));
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        int k;
        @(posedge clk_sys);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {16'h0000, d};
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (waitReq !== 1'b0 && k < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 20)
        begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        bus(a, 1'b0, 16'h0000);
        check(q, {16'h0000, e});
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task automatic pulse(input logic [63:0] ev);
        @(posedge clk_sys);
        srcEvent <= ev;
        @(posedge clk_sys);
        srcEvent <= 64'h0;
        settle(2);
    endtask
    task automatic set_level(input logic [2:0] l);
        @(posedge clk_sys);
        level <= l;
        settle(2);
    endtask
    function automatic logic [23:0] exp_addr(input logic [6:0] v);
        return 24'h000004 + {16'h0000, v, 1'b0};
    endfunction
    task automatic out_chk(input logic r, input logic [6:0] v, input logic [2:0] pr);
        check(32'({irqReq, irqVector, irqPriority}), 32'({r, v, pr}));
        check(32'(irqTableAddr), r ? 32'(exp_addr(v)) : 32'h0);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(8'h60, 16'h8000);
        rd_chk(8'h20, 16'h4444);
        rd_chk(8'h34, 16'h0004);
        rd_chk(8'h74, 16'h0000);
        bus(8'h10, 1'b1, 16'hFFFF);
        rd_chk(8'h10, 16'h7FFF);
        pulse(64'h1 << 15);
        check(32'(irqReq), 32'h0);
        foreach (srcList[i])
        begin
            n = srcList[i];
            p = 3'($unsigned($random(seed)) % 7 + 1);
            bus(8'h10 + 8'(4 * (n / 16)), 1'b1, 16'h1 << (n % 16));
            ackDelay <= 4'($random(seed));
            bus(8'h20 + 8'(4 * (n / 4)), 1'b1, 16'(p) << (4 * (n % 4)));
            pulse(64'h1 << n);
            out_chk(1'b1, 7'(vecList[i]), p);
            check(32'(irqTableAddr), tblList[i]);
            rd_chk(8'(4 * (n / 16)), 16'h1 << (n % 16));
            rd_chk(8'h64, 16'h8000 | (16'(p) << 7) | 16'(vecList[i]));
            bus(8'(4 * (n / 16)), 1'b1, 16'h0000);
            bus(8'h10 + 8'(4 * (n / 16)), 1'b1, 16'h0000);
        end
        bus(8'h10, 1'b1, 16'h0410);
        bus(8'h24, 1'b1, 16'h0005);
        bus(8'h28, 1'b1, 16'h0500);
        pulse(64'h410);
        out_chk(1'b1, 7'h0C, 3'h5);
        bus(8'h28, 1'b1, 16'h0700);
        set_level(3'h6);
        out_chk(1'b1, 7'h12, 3'h7);
        set_level(3'h7);
        out_chk(1'b0, 7'h00, 3'h0);
        set_level(3'h0);
        @(posedge clk_sys);
        disable_instr_active <= 1'b1;
        bus(8'h60, 1'b1, 16'h2000);
        settle(2);
        out_chk(1'b0, 7'h00, 3'h0);
        check(32'(trap), 32'h1);
        rd_chk(8'h60, 16'h6000);
        disable_instr_active <= 1'b0;
        bus(8'h60, 1'b1, 16'h8000);
        settle(2);
        out_chk(1'b1, 7'h12, 3'h7);
        check(32'(trap), 32'h0);
        bus(8'h60, 1'b1, 16'h8001);
        bus(8'h10, 1'b1, 16'h0001);
        bus(8'h00, 1'b1, 16'h0000);
        extPin <= 3'h1;
        repeat (3) @(posedge clk_sys);
        rd_chk(8'h00, 16'h0000);
        extPin <= 3'h0;
        repeat (3) @(posedge clk_sys);
        rd_chk(8'h00, 16'h0001);
        extPin <= 3'h2;
        repeat (3) @(posedge clk_sys);
        rd_chk(8'h04, 16'h0010);
        extPin <= 3'h6;
        repeat (3) @(posedge clk_sys);
        rd_chk(8'h04, 16'h2010);
        bus(8'h68, 1'b0, 16'h0000);
        check(q & 32'h3, 32'h3);
        bus(8'h70, 1'b1, 16'h0002);
        settle(2);
        check(32'(irqOut), 32'h1);
        bus(8'h70, 1'b1, 16'h0000);
        settle(2);
        check(32'(irqOut), 32'h0);
        bus(8'h70, 1'b1, 16'h0002);
        bus(8'h6C, 1'b1, 16'h0003);
        settle(2);
        check(32'(irqOut), 32'h0);
        bus(8'h68, 1'b0, 16'h0000);
        check(q & 32'h2, 32'h0);
        // mid-run reset with pins parked low, then lane-masked and unaligned writes
        extPin <= 3'h0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(8'h04, 16'h0000);
        rd_chk(8'h60, 16'h8000);
        out_chk(1'b0, 7'h00, 3'h0);
        check(32'(irqOut), 32'h0);
        be <= 4'h1;
        bus(8'h20, 1'b1, 16'h7777);
        be <= 4'hF;
        bus(8'h21, 1'b1, 16'h0000);
        rd_chk(8'h20, 16'h4477);
        wrap_up();
    end
endmodule
